// >>> design/stm_pkg.sv
package stm_pkg;

    // Control register bit layout, msb first
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_interrupt_enable;
        logic comparator_capture_enable;
        logic split_mode_select;
        logic run_control;
        logic unused_bit;
        logic external_clock_select;
    } stm_ctrl_t;

    localparam logic [7:0] ADDR_CTRL = 8'hc8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [15:0] WORD_MAX = 16'hffff;
    localparam logic [7:0] READ_NONE = 8'h00;

    // Prescaler terminal counts: divide by 12 and by 8
    localparam logic [3:0] SYS_DIV_LAST = 4'hb;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;

endpackage

// >>> design/stm_tick_gen.sv
`timescale 1ns/1ps

module stm_tick_gen #(
    parameter logic [3:0] SYS_LAST = stm_pkg::SYS_DIV_LAST,
    parameter logic [2:0] EXT_LAST = stm_pkg::EXT_DIV_LAST
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ext_clk_pin,
    input wire logic cmp_async,
    output logic tick_sys,
    output logic tick_ext,
    output logic cmp_rise
);

    logic [1:0] ext_sync_reg, ext_sync_next;
    logic [1:0] cmp_sync_reg, cmp_sync_next;
    logic ext_last_reg, ext_last_next;
    logic cmp_last_reg, cmp_last_next;
    logic [3:0] sys_div_reg, sys_div_next;
    logic [2:0] ext_div_reg, ext_div_next;
    logic tick_sys_reg, tick_sys_next;
    logic tick_ext_reg, tick_ext_next;
    logic cmp_rise_reg, cmp_rise_next;

    always_comb begin
        ext_sync_next = {ext_sync_reg[0], ext_clk_pin};
        cmp_sync_next = {cmp_sync_reg[0], cmp_async};
        ext_last_next = ext_sync_reg[1];
        cmp_last_next = cmp_sync_reg[1];
        sys_div_next = sys_div_reg + 4'h1;
        tick_sys_next = 1'b0;
        if (sys_div_reg == SYS_LAST) begin
            sys_div_next = 4'h0;
            tick_sys_next = 1'b1;
        end
        ext_div_next = ext_div_reg;
        tick_ext_next = 1'b0;
        // External clock counted on synchronised rising edges only
        if (ext_sync_reg[1] && !ext_last_reg) begin
            // Explicit wrap keeps the divide ratio right for any EXT_LAST
            if (ext_div_reg == EXT_LAST) begin
                ext_div_next = 3'h0;
            end else begin
                ext_div_next = ext_div_reg + 3'h1;
            end
            tick_ext_next = (ext_div_reg == EXT_LAST);
        end
        cmp_rise_next = cmp_sync_reg[1] && !cmp_last_reg;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ext_sync_reg <= 2'h0;
            cmp_sync_reg <= 2'h0;
            ext_last_reg <= 1'b0;
            cmp_last_reg <= 1'b0;
            sys_div_reg <= 4'h0;
            ext_div_reg <= 3'h0;
            tick_sys_reg <= 1'b0;
            tick_ext_reg <= 1'b0;
            cmp_rise_reg <= 1'b0;
        end else begin
            ext_sync_reg <= ext_sync_next;
            cmp_sync_reg <= cmp_sync_next;
            ext_last_reg <= ext_last_next;
            cmp_last_reg <= cmp_last_next;
            sys_div_reg <= sys_div_next;
            ext_div_reg <= ext_div_next;
            tick_sys_reg <= tick_sys_next;
            tick_ext_reg <= tick_ext_next;
            cmp_rise_reg <= cmp_rise_next;
        end
    end

    assign tick_sys = tick_sys_reg;
    assign tick_ext = tick_ext_reg;
    assign cmp_rise = cmp_rise_reg;

    property p_sys_period;
        @(posedge sys_clk) disable iff (!nrst)
        tick_sys |-> ##12 tick_sys;
    endproperty
    a_sys_period: assert property (p_sys_period)
        else $error("system prescaler tick period is not twelve");

    property p_one_rise;
        @(posedge sys_clk) disable iff (!nrst)
        cmp_rise |=> !cmp_rise;
    endproperty
    a_one_rise: assert property (p_one_rise)
        else $error("comparator edge produced two capture strobes");

endmodule // stm_tick_gen

// >>> design/stm_timer.sv
`timescale 1ns/1ps

module stm_timer (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic timer_irq_enable,
    input wire logic high_byte_clock_choice,
    input wire logic low_byte_clock_choice,
    input wire logic ext_clk_pin,
    input wire logic analog_comparator_output,
    output logic timer_irq
);

    stm_pkg::stm_ctrl_t ctrl_reg, ctrl_next;
    logic [15:0] count_reg, count_next;
    logic [15:0] reload_reg, reload_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic tick_sys, tick_ext, cmp_rise;
    logic tick_low, tick_high, set_high, set_low;

    stm_tick_gen u_tick (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ext_clk_pin(ext_clk_pin),
        .cmp_async(analog_comparator_output),
        .tick_sys(tick_sys),
        .tick_ext(tick_ext),
        .cmp_rise(cmp_rise)
    );

    // Per-byte choice of one means undivided system clock
    function automatic logic pick_tick(input logic choice, input logic xsel,
                                       input logic t_sys, input logic t_ext);
        return choice ? 1'b1 : (xsel ? t_ext : t_sys);
    endfunction

    function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                    input logic [7:0] target);
        return wr && (addr == target);
    endfunction

    always_comb begin
        tick_low = pick_tick(low_byte_clock_choice,
            ctrl_reg.external_clock_select, tick_sys, tick_ext);
        tick_high = pick_tick(high_byte_clock_choice,
            ctrl_reg.external_clock_select, tick_sys, tick_ext);
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        count_next = count_reg;
        reload_next = reload_reg;
        set_high = 1'b0;
        set_low = 1'b0;
        if (!ctrl_reg.split_mode_select) begin
            if (ctrl_reg.run_control && tick_low) begin
                if (count_reg == stm_pkg::WORD_MAX) begin
                    count_next = reload_reg;
                    set_high = 1'b1;
                end else begin
                    count_next = count_reg + 16'h0001;
                end
                if (count_reg[7:0] == stm_pkg::BYTE_MAX) begin
                    set_low = 1'b1;
                end
            end
        end else begin
            // Lower byte free-runs in split mode
            if (tick_low) begin
                if (count_reg[7:0] == stm_pkg::BYTE_MAX) begin
                    count_next[7:0] = reload_reg[7:0];
                    set_low = 1'b1;
                end else begin
                    count_next[7:0] = count_reg[7:0] + 8'h01;
                end
            end
            if (ctrl_reg.run_control && tick_high) begin
                if (count_reg[15:8] == stm_pkg::BYTE_MAX) begin
                    count_next[15:8] = reload_reg[15:8];
                    set_high = 1'b1;
                end else begin
                    count_next[15:8] = count_reg[15:8] + 8'h01;
                end
            end
        end
        if (wr_hit(sfr_wr, sfr_addr, stm_pkg::ADDR_COUNT_LOW)) begin
            count_next[7:0] = sfr_wdata;
        end
        if (wr_hit(sfr_wr, sfr_addr, stm_pkg::ADDR_COUNT_HIGH)) begin
            count_next[15:8] = sfr_wdata;
        end
        if (wr_hit(sfr_wr, sfr_addr, stm_pkg::ADDR_RELOAD_LOW)) begin
            reload_next[7:0] = sfr_wdata;
        end
        if (wr_hit(sfr_wr, sfr_addr, stm_pkg::ADDR_RELOAD_HIGH)) begin
            reload_next[15:8] = sfr_wdata;
        end
        // Capture beats a same-cycle software reload write
        if (ctrl_reg.comparator_capture_enable && cmp_rise) begin
            reload_next = count_reg;
            set_high = 1'b1;
        end
        if (wr_hit(sfr_wr, sfr_addr, stm_pkg::ADDR_CTRL)) begin
            ctrl_next = stm_pkg::stm_ctrl_t'(sfr_wdata);
        end
        ctrl_next.unused_bit = 1'b0;
        // Hardware set wins over a software clear in the same cycle
        ctrl_next.high_overflow_flag =
            ctrl_next.high_overflow_flag | set_high;
        ctrl_next.low_overflow_flag =
            ctrl_next.low_overflow_flag | set_low;
        irq_next = timer_irq_enable && (ctrl_reg.high_overflow_flag
            || (ctrl_reg.low_overflow_flag
                && ctrl_reg.low_interrupt_enable));
        case (sfr_addr)
            stm_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
            stm_pkg::ADDR_RELOAD_LOW: rdata_next = reload_reg[7:0];
            stm_pkg::ADDR_RELOAD_HIGH: rdata_next = reload_reg[15:8];
            stm_pkg::ADDR_COUNT_LOW: rdata_next = count_reg[7:0];
            stm_pkg::ADDR_COUNT_HIGH: rdata_next = count_reg[15:8];
            default: rdata_next = stm_pkg::READ_NONE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= stm_pkg::stm_ctrl_t'(stm_pkg::CTRL_RESET);
            count_reg <= stm_pkg::COUNT_RESET;
            reload_reg <= stm_pkg::RELOAD_RESET;
            rdata_reg <= stm_pkg::READ_NONE;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            count_reg <= count_next;
            reload_reg <= reload_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign timer_irq = irq_reg;

    property p_high_wrap;
        @(posedge sys_clk) disable iff (!nrst)
        ctrl_reg.split_mode_select && ctrl_reg.run_control && tick_high
            && count_reg[15:8] == stm_pkg::BYTE_MAX && !sfr_wr
            |=> ctrl_reg.high_overflow_flag
            && count_reg[15:8] == $past(reload_reg[15:8]);
    endproperty
    a_high_wrap: assert property (p_high_wrap)
        else $error("upper byte wrap did not set flag or reload");

    property p_word_wrap;
        @(posedge sys_clk) disable iff (!nrst)
        !ctrl_reg.split_mode_select && ctrl_reg.run_control && tick_low
            && count_reg == 16'hffff && !sfr_wr
            |=> ctrl_reg.high_overflow_flag && ctrl_reg.low_overflow_flag
            && count_reg == $past(reload_reg);
    endproperty
    a_word_wrap: assert property (p_word_wrap)
        else $error("16-bit wrap did not set flags or reload");

    property p_high_irq;
        @(posedge sys_clk) disable iff (!nrst)
        timer_irq_enable && ctrl_reg.high_overflow_flag |=> timer_irq;
    endproperty
    a_high_irq: assert property (p_high_irq)
        else $error("high flag did not raise interrupt");

    property p_low_wrap;
        @(posedge sys_clk) disable iff (!nrst)
        ctrl_reg.split_mode_select && tick_low && !sfr_wr
            && count_reg[7:0] == stm_pkg::BYTE_MAX
            |=> ctrl_reg.low_overflow_flag
            && count_reg[7:0] == $past(reload_reg[7:0]);
    endproperty
    a_low_wrap: assert property (p_low_wrap)
        else $error("lower byte wrap did not set flag or reload");

    property p_low_irq;
        @(posedge sys_clk) disable iff (!nrst)
        timer_irq_enable && ctrl_reg.low_overflow_flag
            && ctrl_reg.low_interrupt_enable |=> timer_irq;
    endproperty
    a_low_irq: assert property (p_low_irq)
        else $error("low flag with enable did not raise interrupt");

    property p_capture;
        @(posedge sys_clk) disable iff (!nrst)
        ctrl_reg.comparator_capture_enable && cmp_rise
            |=> reload_reg == $past(count_reg);
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not copy the count");

    property p_capture_irq;
        @(posedge sys_clk) disable iff (!nrst)
        timer_irq_enable && ctrl_reg.comparator_capture_enable && cmp_rise
            ##1 timer_irq_enable |=> timer_irq;
    endproperty
    a_capture_irq: assert property (p_capture_irq)
        else $error("capture did not raise interrupt");

    property p_word_count;
        @(posedge sys_clk) disable iff (!nrst)
        !ctrl_reg.split_mode_select && ctrl_reg.run_control && tick_low
            && count_reg != 16'hffff && !sfr_wr
            |=> count_reg == $past(count_reg) + 16'h0001;
    endproperty
    a_word_count: assert property (p_word_count)
        else $error("16-bit count did not advance");

    property p_high_gated;
        @(posedge sys_clk) disable iff (!nrst)
        ctrl_reg.split_mode_select && !ctrl_reg.run_control && !sfr_wr
            |=> $stable(count_reg[15:8]);
    endproperty
    a_high_gated: assert property (p_high_gated)
        else $error("upper byte moved while stopped");

    property p_split_source;
        @(posedge sys_clk) disable iff (!nrst)
        !low_byte_clock_choice && ctrl_reg.external_clock_select
            |-> tick_low == tick_ext;
    endproperty
    a_split_source: assert property (p_split_source)
        else $error("low byte not on external source");

    property p_unused_zero;
        @(posedge sys_clk) disable iff (!nrst)
        $past(sfr_addr) == stm_pkg::ADDR_CTRL |-> !sfr_rdata[1];
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused control bit read as one");

endmodule // stm_timer

// >>> dv/stm_timer_tb.sv
`timescale 1ns/1ps

module stm_timer_tb;
    logic sys_clk;
    logic nrst;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic timer_irq_enable;
    logic high_byte_clock_choice;
    logic low_byte_clock_choice;
    logic ext_clk_pin;
    logic analog_comparator_output;
    logic timer_irq;
    logic [7:0] rd;
    logic [7:0] rl;
    int n_fail;
    int n_tests;
    int cyc;
    int m_rld;
    int m_cnt;

    stm_timer dut_u (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .timer_irq_enable(timer_irq_enable),
        .high_byte_clock_choice(high_byte_clock_choice),
        .low_byte_clock_choice(low_byte_clock_choice),
        .ext_clk_pin(ext_clk_pin),
        .analog_comparator_output(analog_comparator_output),
        .timer_irq(timer_irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Inputs move 2 ns after the edge, clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
        tick(1);
    endtask

    // Read data is registered from the address seen at the edge
    task automatic rdreg(input logic [7:0] a);
        sfr_addr = a;
        tick(1);
        rd = sfr_rdata;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkrd(input string what, input logic [7:0] a,
                         input logic [7:0] exp);
        rdreg(a);
        chk(what, exp, rd);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run needs well under 3000 cycles
    initial begin
        #500000;
        n_fail++;
        stop_test();
    end

    initial begin
        void'($urandom(32'ha94c43f9));
        nrst = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        timer_irq_enable = 1'b1;
        high_byte_clock_choice = 1'b0;
        low_byte_clock_choice = 1'b0;
        ext_clk_pin = 1'b0;
        analog_comparator_output = 1'b0;
        repeat (6) @(posedge sys_clk);
        #2;
        nrst = 1'b1;
        // Reset values, c9 is unmapped
        for (int i = 0; i < 6; i++) begin
            chkrd("reset value", 8'hc8 + 8'(i), 8'h00);
        end
        wr(stm_pkg::ADDR_CTRL, 8'h02);
        chkrd("unused bit", stm_pkg::ADDR_CTRL, 8'h00);
        // Split, run, external: both bytes count pin edges over 8
        wr(stm_pkg::ADDR_CTRL, 8'h0d);
        repeat (16) begin
            ext_clk_pin = 1'b1;
            tick(4);
            ext_clk_pin = 1'b0;
            tick(4);
        end
        tick(8);
        chkrd("ext count high", stm_pkg::ADDR_COUNT_HIGH, 8'h02);
        chkrd("ext count low", stm_pkg::ADDR_COUNT_LOW, 8'h02);
        // Per-byte choice: upper byte on every edge, wraps to reload
        wr(stm_pkg::ADDR_COUNT_HIGH, 8'hf8);
        high_byte_clock_choice = 1'b1;
        tick(16);
        high_byte_clock_choice = 1'b0;
        chkrd("fast count high", stm_pkg::ADDR_COUNT_HIGH, 8'h08);
        chkrd("high wrap flag", stm_pkg::ADDR_CTRL, 8'h8d);
        wr(stm_pkg::ADDR_CTRL, 8'h00);
        // Split with run off: lower byte still runs, upper holds
        low_byte_clock_choice = 1'b1;
        rl = 8'(8'hc0 + $urandom_range(0, 63));
        wr(stm_pkg::ADDR_RELOAD_LOW, rl);
        wr(stm_pkg::ADDR_COUNT_HIGH, 8'h5a);
        wr(stm_pkg::ADDR_CTRL, 8'h28);
        tick(300);
        rdreg(stm_pkg::ADDR_CTRL);
        chk("split flags", 8'h40, rd & 8'hc0);
        chkrd("held high byte", stm_pkg::ADDR_COUNT_HIGH, 8'h5a);
        chk("low irq", 8'h01, {7'h00, timer_irq});
        rdreg(stm_pkg::ADDR_COUNT_LOW);
        chk("low in reload span", 8'h01, {7'h00, rd >= rl});
        timer_irq_enable = 1'b0;
        tick(2);
        chk("masked irq", 8'h00, {7'h00, timer_irq});
        timer_irq_enable = 1'b1;
        wr(stm_pkg::ADDR_CTRL, 8'h00);
        // Full width, system clock over 12, ten ticks to wrap
        low_byte_clock_choice = 1'b0;
        m_rld = $urandom_range(0, 65535);
        wr(stm_pkg::ADDR_RELOAD_LOW, m_rld[7:0]);
        wr(stm_pkg::ADDR_RELOAD_HIGH, m_rld[15:8]);
        wr(stm_pkg::ADDR_COUNT_LOW, 8'hf6);
        wr(stm_pkg::ADDR_COUNT_HIGH, 8'hff);
        wr(stm_pkg::ADDR_CTRL, 8'h04);
        cyc = 0;
        do begin
            rdreg(stm_pkg::ADDR_CTRL);
            cyc++;
        end while (rd[7] !== 1'b1 && cyc < 400);
        // Stop within one prescale period so the reload stays visible
        wr(stm_pkg::ADDR_CTRL, 8'hc0);
        chk("wrap time", 8'h01, {7'h00, cyc >= 105 && cyc <= 125});
        chkrd("reload low", stm_pkg::ADDR_COUNT_LOW, m_rld[7:0]);
        chkrd("reload high", stm_pkg::ADDR_COUNT_HIGH, m_rld[15:8]);
        tick(20);
        chkrd("wrap flags", stm_pkg::ADDR_CTRL, 8'hc0);
        chk("high irq", 8'h01, {7'h00, timer_irq});
        wr(stm_pkg::ADDR_CTRL, 8'h00);
        tick(2);
        chk("irq after clear", 8'h00, {7'h00, timer_irq});
        // Capture of a stopped count on comparator rise
        m_cnt = $urandom_range(0, 65535);
        wr(stm_pkg::ADDR_COUNT_LOW, m_cnt[7:0]);
        wr(stm_pkg::ADDR_COUNT_HIGH, m_cnt[15:8]);
        wr(stm_pkg::ADDR_RELOAD_LOW, 8'h00);
        wr(stm_pkg::ADDR_RELOAD_HIGH, 8'h00);
        wr(stm_pkg::ADDR_CTRL, 8'h10);
        analog_comparator_output = 1'b1;
        tick(8);
        chkrd("capt low", stm_pkg::ADDR_RELOAD_LOW, m_cnt[7:0]);
        chkrd("capt high", stm_pkg::ADDR_RELOAD_HIGH, m_cnt[15:8]);
        chkrd("capt flag", stm_pkg::ADDR_CTRL, 8'h90);
        chk("capt irq", 8'h01, {7'h00, timer_irq});
        // A held high level must not capture again
        wr(stm_pkg::ADDR_COUNT_LOW, ~m_cnt[7:0]);
        tick(10);
        chkrd("one capture", stm_pkg::ADDR_RELOAD_LOW, m_cnt[7:0]);
        analog_comparator_output = 1'b0;
        wr(stm_pkg::ADDR_CTRL, 8'h00);
        tick(4);
        analog_comparator_output = 1'b1;
        tick(8);
        chkrd("no capt off", stm_pkg::ADDR_RELOAD_LOW, m_cnt[7:0]);
        stop_test();
    end
endmodule // stm_timer_tb
